// ==== bench/asft_monitor.sv ====
// Purpose: port checks on the serial port top
// Assumes: one clock, rst active high
// Notes:   the bench uses the alternate pin pair
`timescale 1ns/1ns
module asft_monitor (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       prim_port_out,
  input wire logic       alt_port_out,
  input wire logic       prim_tx_pin,
  input wire logic       alt_tx_pin,
  input wire logic       prim_tx_owned,
  input wire logic       alt_tx_owned,
  input wire logic       alt_rx_owned,
  input wire logic       tx_complete_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_idle2; $stable(alt_tx_pin)[*2]; endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  a_irq_pulse: assert property (tx_complete_irq |=> !tx_complete_irq)
    else $error("irq longer than a cycle");
  a_irq_owned: assert property (tx_complete_irq |-> alt_tx_owned || prim_tx_owned)
    else $error("irq with transmit off");
  a_idle_after: assert property (tx_complete_irq |=> s_idle2)
    else $error("line moved after frame");
  a_pair_excl: assert property (!(prim_tx_owned && alt_tx_owned))
    else $error("both pairs owned");
  a_pair_rx: assert property (alt_rx_owned |-> !prim_tx_owned)
    else $error("mixed pairs owned");
  a_prim_pass: assert property (!prim_tx_owned |-> prim_tx_pin == prim_port_out)
    else $error("primary pin not released");
  a_alt_pass: assert property (!alt_tx_owned |-> alt_tx_pin == alt_port_out)
    else $error("alternate pin not released");
endmodule
bind asft_top asft_monitor i_asft_monitor (.ref_clk(ref_clk), .rst(rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .prim_port_out(prim_port_out), .alt_port_out(alt_port_out),
  .prim_tx_pin(prim_tx_pin), .alt_tx_pin(alt_tx_pin), .prim_tx_owned(prim_tx_owned),
  .alt_tx_owned(alt_tx_owned), .alt_rx_owned(alt_rx_owned), .tx_complete_irq(tx_complete_irq));

// ==== bench/asft_partner.sv ====
// Purpose: far-side receiver sampling the line mid-bit
// Assumes: line normalised to idle high
// Notes:   a low gone by mid start is a glitch and is dropped
`timescale 1ns/1ns
module asft_partner #(parameter int BIT_CLKS = 4) (
  input wire logic        ref_clk,
  input wire logic        line,
  input wire logic [3:0]  nbits,
  output logic     [11:0] bits,
  output logic            got
);
  int k;
  initial begin
    got = 1'b0;
    bits = 12'h000;
    forever begin
      @(negedge line);
      repeat (BIT_CLKS / 2) @(posedge ref_clk);
      if (line) continue;
      bits = 12'h000;
      for (k = 0; k < nbits; k++) begin
        bits[k] = line;
        repeat (BIT_CLKS) @(posedge ref_clk);
      end
      got <= 1'b1;
      @(posedge ref_clk);
      got <= 1'b0;
    end
  end
endmodule

// ==== bench/tb_asft_top.sv ====
// Purpose: register-driven frame tests of the serial port
// Assumes: alternate pair, prescale 1, divisor 4: a bit is 4 clocks
// Notes:   receive side is fed by loopback; inverted frames are not read back
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t mismatch %h %h", $time, a, b); end end
module tb_asft_top;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, inv = 1'b0, got;
  logic [3:0] reg_addr = 4'h0, nb = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d, m, c;
  logic alt_tx_pin, alt_tx_owned, tx_complete_irq, p_own, p_pin;
  logic [11:0] bits, ev;
  int fail_count = 0, n_checks = 0;
  localparam logic [23:0] CS [6] = '{24'h551c02, 24'h551c00, 24'h551c01, 24'h361202,
                                     24'h870402, 24'ha50e00};
  always #5 ref_clk = ~ref_clk;
  asft_top i_asft_top (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .prim_rx_pin(1'b1), .alt_rx_pin(alt_tx_pin), .prim_port_out(1'b0),
    .alt_port_out(1'b1),
    .prim_tx_pin(p_pin), .alt_tx_pin(alt_tx_pin), .prim_tx_owned(p_own), .prim_rx_owned(),
    .alt_tx_owned(alt_tx_owned), .alt_rx_owned(), .tx_complete_irq(tx_complete_irq));
  asft_partner i_asft_partner (.ref_clk(ref_clk), .line(alt_tx_owned ? alt_tx_pin ^ inv : 1'b1),
    .nbits(nb), .bits(bits), .got(got));
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wfor(input bit use_got);
    int i;
    for (i = 0; i < 400 && !(use_got ? got : tx_complete_irq); i++) @(posedge ref_clk);
    if (i == 400) begin
      fail_count++;
      finish_test();
    end
  endtask
  function automatic logic [11:0] expf(input logic [7:0] v, input logic [7:0] md,
                                       input logic lsb, output logic [3:0] n);
    int i;
    int w;
    expf = 12'h000;
    w = md[2] ? 8 : 7;
    n = 4'h1;
    for (i = 0; i < w; i++) begin
      expf[n] = lsb ? v[i] : v[w - 1 - i];
      n++;
    end
    if (md[4:3] != 2'h0) begin
      expf[n] = (md[4:3] == 2'h1) ? 1'b0 : (^(v & (md[2] ? 8'hff : 8'h7f))) ^ (md[4:3] == 2'h2);
      n++;
    end
    expf[n] = 1'b1;
    n++;
    if (md[1]) begin
      expf[n] = 1'b1;
      n++;
    end
  endfunction
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(4'h0, 8'h01);
    rd_chk(4'hf, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h04);
    foreach (CS[j]) begin
      {d, m, c} = CS[j];
      inv = c[0];
      ev = expf(d, m, c[1], nb);
      wr(4'h0, m);
      wr(4'h5, c);
      wr(4'h0, 8'h80 | m);
      wr(4'h0, 8'he0 | m);
      wr(4'h7, d);
      wfor(1'b0);
      wfor(1'b1);
      `CHK(bits & ((12'h001 << nb) - 12'h001), ev)
      rd_chk(4'h2, 8'h00);
      if (!c[0]) begin
        rd_chk(4'h1, 8'h00);
        rd_chk(4'h8, m[2] ? d : {1'b0, d[6:0]});
      end
      wr(4'h0, 8'h80 | m);
      wr(4'h0, m);
    end
    wr(4'h6, 8'h10);
    wr(4'h0, 8'h84);
    wr(4'h0, 8'hc4);
    #1 `CHK({p_own, alt_tx_owned, p_pin, alt_tx_pin}, 4'hb)
    rd_chk(4'h6, 8'h10);
    finish_test();
  end
endmodule

// ==== rtl/asft_defs.svh ====
// Purpose: register offsets, field positions and reset values of the serial port
// Assumes: 4-bit register index, 8-bit register data
// Notes:   one aligned byte register per index
`ifndef ASFT_DEFS_SVH
`define ASFT_DEFS_SVH

`define ASFT_AW               4
`define ASFT_DW               8

`define ASFT_ADDR_MODE        4'h0
`define ASFT_ADDR_RX_ERR      4'h1
`define ASFT_ADDR_TX_STAT     4'h2
`define ASFT_ADDR_CLK_SEL     4'h3
`define ASFT_ADDR_DIVISOR     4'h4
`define ASFT_ADDR_CONTROL     4'h5
`define ASFT_ADDR_IN_SWITCH   4'h6
`define ASFT_ADDR_TX_BUF      4'h7
`define ASFT_ADDR_RX_BUF      4'h8

`define ASFT_MODE_RESET       8'h01
`define ASFT_CTRL_RESET       8'h02
`define ASFT_ZERO_BYTE        8'h00
`define ASFT_DIV_RESET        8'hff

`define ASFT_MODE_POWER       7
`define ASFT_MODE_TXE         6
`define ASFT_MODE_RXE         5
`define ASFT_MODE_PAR_HI      4
`define ASFT_MODE_PAR_LO      3
`define ASFT_MODE_CHAR8       2
`define ASFT_MODE_STOP2       1
`define ASFT_CTRL_LSB_FIRST   1
`define ASFT_CTRL_INVERT      0
`define ASFT_SW_SEL_HI        5
`define ASFT_SW_SEL_LO        4
`define ASFT_SEL_ALTERNATE    2'h0
`define ASFT_SEL_PRIMARY      2'h1
`define ASFT_ERR_PARITY       2
`define ASFT_ERR_FRAMING      1
`define ASFT_ERR_OVERRUN      0
`define ASFT_STAT_BUF_FULL    1
`define ASFT_STAT_SHIFTING    0
`define ASFT_CKSEL_W          4

`define ASFT_CNT_ONE          8'h01
`define ASFT_CHAR8_LAST       3'h7
`define ASFT_CHAR7_LAST       3'h6
`define ASFT_BIT_ONE          3'h1

`endif

// ==== rtl/asft_pkg.sv ====
// Purpose: types and shared helper functions of the serial port
// Assumes: character data is at most 8 bits
// Notes:   bit ordering helper is its own inverse, so tx and rx share it
package asft_pkg;

  typedef enum logic [2:0] {
    ASFT_TX_IDLE   = 3'h0,
    ASFT_TX_START  = 3'h1,
    ASFT_TX_DATA   = 3'h3,
    ASFT_TX_PARITY = 3'h2,
    ASFT_TX_STOP   = 3'h6
  } asft_tx_state_t;

  typedef enum logic [2:0] {
    ASFT_RX_IDLE   = 3'h0,
    ASFT_RX_START  = 3'h1,
    ASFT_RX_DATA   = 3'h3,
    ASFT_RX_PARITY = 3'h2,
    ASFT_RX_STOP   = 3'h6
  } asft_rx_state_t;

  typedef enum logic [1:0] {
    ASFT_PAR_NONE = 2'h0,
    ASFT_PAR_ZERO = 2'h1,
    ASFT_PAR_ODD  = 2'h2,
    ASFT_PAR_EVEN = 2'h3
  } asft_parity_t;

  // maps a character to line order (bit 0 goes first) and back again
  function automatic logic [7:0] asft_order(input logic [7:0] d, input logic char8,
                                            input logic lsb_first);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (char8) r[i] = d[7 - i];
      else if (i < 7) r[i] = d[6 - i];
    end
    if (lsb_first) return char8 ? d : {1'b0, d[6:0]};
    return r;
  endfunction

  function automatic logic asft_ones_odd(input logic [7:0] d, input logic char8);
    return char8 ? ^d : ^d[6:0];
  endfunction

  function automatic logic [7:0] asft_div_eff(input logic [7:0] div);
    return (div == 8'h00) ? 8'h01 : div;
  endfunction

endpackage

// ==== rtl/asft_rx.sv ====
// Purpose: receive half of the serial port, one frame at a time
// Assumes: rx_line is forced high by the parent while reception is off
// Notes:   only one stop bit is checked; a second one looks like idle
`timescale 1ns/1ns
`include "asft_defs.svh"
module asft_rx (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       rx_line,
  input  wire logic       pre_tick,
  input  wire logic [7:0] divisor,
  input  wire logic       char8,
  input  wire logic [1:0] parity_mode,
  input  wire logic       lsb_first,
  output logic            done,
  output logic [7:0]      data,
  output logic            parity_err,
  output logic            framing_err
);
  asft_pkg::asft_rx_state_t state_reg;
  logic [7:0] shift_reg;
  logic [7:0] cnt_reg;
  logic [2:0] bit_reg;
  logic       acc_reg;
  logic [7:0] lim;
  logic       sample;
  logic [7:0] line_bits;

  // the start bit is checked half a bit in, later bits in their middle
  assign lim = (state_reg == asft_pkg::ASFT_RX_START) ?
               asft_pkg::asft_div_eff({1'b0, divisor[7:1]}) : asft_pkg::asft_div_eff(divisor);
  assign sample = pre_tick && (cnt_reg == lim - `ASFT_CNT_ONE);
  assign line_bits = char8 ? shift_reg : {1'b0, shift_reg[7:1]};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= `ASFT_ZERO_BYTE;
    end else if (clear || state_reg == asft_pkg::ASFT_RX_IDLE || sample) begin
      cnt_reg <= `ASFT_ZERO_BYTE;
    end else if (pre_tick) begin
      cnt_reg <= cnt_reg + `ASFT_CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg   <= asft_pkg::ASFT_RX_IDLE;
      shift_reg   <= `ASFT_ZERO_BYTE;
      bit_reg     <= 3'h0;
      acc_reg     <= 1'b0;
      done        <= 1'b0;
      data        <= `ASFT_ZERO_BYTE;
      parity_err  <= 1'b0;
      framing_err <= 1'b0;
    end else if (clear) begin
      state_reg <= asft_pkg::ASFT_RX_IDLE;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        asft_pkg::ASFT_RX_IDLE: begin
          if (!rx_line) begin
            state_reg <= asft_pkg::ASFT_RX_START;
          end
        end
        asft_pkg::ASFT_RX_START: begin
          if (sample) begin
            state_reg <= rx_line ? asft_pkg::ASFT_RX_IDLE : asft_pkg::ASFT_RX_DATA;
            bit_reg   <= 3'h0;
            acc_reg   <= 1'b0;
          end
        end
        asft_pkg::ASFT_RX_DATA: begin
          if (sample) begin
            shift_reg <= {rx_line, shift_reg[7:1]};
            acc_reg   <= acc_reg ^ rx_line;
            bit_reg   <= bit_reg + `ASFT_BIT_ONE;
            if (bit_reg == (char8 ? `ASFT_CHAR8_LAST : `ASFT_CHAR7_LAST)) begin
              state_reg <= (parity_mode == asft_pkg::ASFT_PAR_NONE) ?
                           asft_pkg::ASFT_RX_STOP : asft_pkg::ASFT_RX_PARITY;
            end
          end
        end
        asft_pkg::ASFT_RX_PARITY: begin
          if (sample) begin
            acc_reg   <= acc_reg ^ rx_line;
            state_reg <= asft_pkg::ASFT_RX_STOP;
          end
        end
        asft_pkg::ASFT_RX_STOP: begin
          if (sample) begin
            state_reg   <= asft_pkg::ASFT_RX_IDLE;
            done        <= 1'b1;
            data        <= asft_pkg::asft_order(line_bits, char8, lsb_first);
            framing_err <= !rx_line;
            case (parity_mode)
              asft_pkg::ASFT_PAR_EVEN: parity_err <= acc_reg;
              asft_pkg::ASFT_PAR_ODD:  parity_err <= !acc_reg;
              default:                 parity_err <= 1'b0;
            endcase
          end
        end
        default: state_reg <= asft_pkg::ASFT_RX_IDLE;
      endcase
    end
  end

endmodule

// ==== rtl/asft_top.sv ====
// Purpose: asynchronous serial port, uart mode, with register port and pin pair choice
// Assumes: pins and register port are synchronous to ref_clk
// Notes:   one frame per buffer write; no interrupt logic beyond the completion pulse
//
// Functional notes
// - Port owns each pin only when enabled.
// - Switch field picks primary or alternate pin pair.
// - Frame: start, 7/8 data, parity, 1/2 stops.
// - Bit order control picks lsb or msb first.
// - Level control inverts the whole transmit frame.
// - Even parity transmit makes ones count even.
// - Even parity receive flags odd ones count.
// - Odd parity transmit makes ones count odd.
// - Odd parity receive flags even ones count.
// - Zero parity sends 0, never checks.
// - No parity: no parity slot, no error.
// - Buffer write with power and transmit starts frame.
// - Buffer copied to shifter, one bit per baud.
// - Completion pulse right after last stop bit.
// - Idle after frame until next buffer write.
// - Power off resets port, line high, input high.
// - Enable bit clear resets its own half.
`timescale 1ns/1ns
`include "asft_defs.svh"
module asft_top (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic [`ASFT_AW-1:0]  reg_addr,
  input  wire logic [`ASFT_DW-1:0]  reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [`ASFT_DW-1:0]  reg_rdata,
  input  wire logic                 prim_rx_pin,
  input  wire logic                 alt_rx_pin,
  input  wire logic                 prim_port_out,
  input  wire logic                 alt_port_out,
  output logic                      prim_tx_pin,
  output logic                      alt_tx_pin,
  output logic                      prim_tx_owned,
  output logic                      prim_rx_owned,
  output logic                      alt_tx_owned,
  output logic                      alt_rx_owned,
  output logic                      tx_complete_irq
);
  logic [7:0] serial_mode_reg;
  logic [7:0] rx_error_status_reg;
  logic [7:0] baud_clock_select_reg;
  logic [7:0] baud_divisor_reg;
  logic [7:0] serial_control_reg;
  logic [7:0] input_switch_reg;
  logic [7:0] transmit_buffer;
  logic [7:0] rx_buffer_reg;
  logic       rx_buf_full_reg;
  logic       buf_full_reg;
  logic [7:0] rdata_next;

  logic                     power_enable_bit;
  logic                     transmit_enable_bit;
  logic                     receive_enable_bit;
  logic                     char_length_bit;
  logic                     stop_length_bit;
  logic                     bit_order_bit;
  logic                     tx_level_invert_bit;
  logic [1:0]               pin_source;
  asft_pkg::asft_parity_t   parity_mode;
  logic                     sel_primary;
  logic                     sel_alternate;
  logic                     tx_run;
  logic                     rx_run;

  logic [15:0] pre_cnt_reg;
  logic [15:0] pre_lim;
  logic        pre_tick;

  asft_pkg::asft_tx_state_t tx_state_reg;
  logic [7:0]  transmit_shifter;
  logic [7:0]  baud_cnt_reg;
  logic [2:0]  tx_bit_reg;
  logic        tx_stop2_reg;
  logic        tx_par_reg;
  logic        tx_line_reg;
  logic        serial_out_pin;
  logic        bit_tick;
  logic        frame_active;
  logic        load_frame;
  logic        wr_tx_buf;

  logic        rx_line;
  logic        rx_done;
  logic [7:0]  rx_data;
  logic        rx_perr;
  logic        rx_ferr;
  logic        rd_err;
  logic        rd_rxbuf;

  assign power_enable_bit    = serial_mode_reg[`ASFT_MODE_POWER];
  assign transmit_enable_bit = serial_mode_reg[`ASFT_MODE_TXE];
  assign receive_enable_bit  = serial_mode_reg[`ASFT_MODE_RXE];
  assign char_length_bit     = serial_mode_reg[`ASFT_MODE_CHAR8];
  assign stop_length_bit     = serial_mode_reg[`ASFT_MODE_STOP2];
  assign parity_mode         = asft_pkg::asft_parity_t'(
                                 {serial_mode_reg[`ASFT_MODE_PAR_HI],
                                  serial_mode_reg[`ASFT_MODE_PAR_LO]});
  assign bit_order_bit       = serial_control_reg[`ASFT_CTRL_LSB_FIRST];
  assign tx_level_invert_bit = serial_control_reg[`ASFT_CTRL_INVERT];
  assign pin_source          = {input_switch_reg[`ASFT_SW_SEL_HI],
                                input_switch_reg[`ASFT_SW_SEL_LO]};
  assign sel_primary         = (pin_source == `ASFT_SEL_PRIMARY);
  assign sel_alternate       = (pin_source == `ASFT_SEL_ALTERNATE);
  assign tx_run              = power_enable_bit && transmit_enable_bit;
  assign rx_run              = power_enable_bit && receive_enable_bit;

  // register port

  assign wr_tx_buf = reg_wr && (reg_addr == `ASFT_ADDR_TX_BUF);
  assign rd_err    = reg_rd && (reg_addr == `ASFT_ADDR_RX_ERR);
  assign rd_rxbuf  = reg_rd && (reg_addr == `ASFT_ADDR_RX_BUF);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serial_mode_reg       <= `ASFT_MODE_RESET;
      baud_clock_select_reg <= `ASFT_ZERO_BYTE;
      baud_divisor_reg      <= `ASFT_DIV_RESET;
      serial_control_reg    <= `ASFT_CTRL_RESET;
      input_switch_reg      <= `ASFT_ZERO_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == `ASFT_ADDR_MODE) begin
        serial_mode_reg <= reg_wdata;
      end else if (reg_addr == `ASFT_ADDR_CLK_SEL) begin
        baud_clock_select_reg <= {4'h0, reg_wdata[`ASFT_CKSEL_W-1:0]};
      end else if (reg_addr == `ASFT_ADDR_DIVISOR) begin
        baud_divisor_reg <= reg_wdata;
      end else if (reg_addr == `ASFT_ADDR_CONTROL) begin
        serial_control_reg <= {6'h00, reg_wdata[1:0]};
      end else if (reg_addr == `ASFT_ADDR_IN_SWITCH) begin
        input_switch_reg <= {2'h0, reg_wdata[5:0]};
      end
    end
  end

  // buffer writes are dropped unless the transmitter is running
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      transmit_buffer <= `ASFT_ZERO_BYTE;
    end else if (wr_tx_buf && tx_run) begin
      transmit_buffer <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      buf_full_reg <= 1'b0;
    end else if (!tx_run) begin
      buf_full_reg <= 1'b0;
    end else if (wr_tx_buf) begin
      buf_full_reg <= 1'b1;
    end else if (load_frame) begin
      buf_full_reg <= 1'b0;
    end
  end

  always_comb begin
    rdata_next = `ASFT_ZERO_BYTE;
    if (reg_addr == `ASFT_ADDR_MODE) begin
      rdata_next = serial_mode_reg;
    end else if (reg_addr == `ASFT_ADDR_RX_ERR) begin
      rdata_next = rx_error_status_reg;
    end else if (reg_addr == `ASFT_ADDR_TX_STAT) begin
      rdata_next = {6'h00, buf_full_reg, frame_active};
    end else if (reg_addr == `ASFT_ADDR_CLK_SEL) begin
      rdata_next = baud_clock_select_reg;
    end else if (reg_addr == `ASFT_ADDR_DIVISOR) begin
      rdata_next = baud_divisor_reg;
    end else if (reg_addr == `ASFT_ADDR_CONTROL) begin
      rdata_next = serial_control_reg;
    end else if (reg_addr == `ASFT_ADDR_IN_SWITCH) begin
      rdata_next = input_switch_reg;
    end else if (reg_addr == `ASFT_ADDR_TX_BUF) begin
      rdata_next = transmit_buffer;
    end else if (reg_addr == `ASFT_ADDR_RX_BUF) begin
      rdata_next = rx_buffer_reg;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `ASFT_ZERO_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= `ASFT_ZERO_BYTE;
    end
  end

  // baud timing: prescaler of 2^select clocks, bit period of divisor prescaled ticks

  assign pre_lim  = 16'h0001 << baud_clock_select_reg[`ASFT_CKSEL_W-1:0];
  assign pre_tick = power_enable_bit && (pre_cnt_reg == pre_lim - 16'h0001);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_cnt_reg <= 16'h0000;
    end else if (!power_enable_bit || pre_tick) begin
      pre_cnt_reg <= 16'h0000;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 16'h0001;
    end
  end

  assign frame_active = (tx_state_reg != asft_pkg::ASFT_TX_IDLE);
  assign load_frame   = tx_run && !frame_active && buf_full_reg;
  assign bit_tick     = pre_tick &&
                        (baud_cnt_reg == asft_pkg::asft_div_eff(baud_divisor_reg) - `ASFT_CNT_ONE);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      baud_cnt_reg <= `ASFT_ZERO_BYTE;
    end else if (!frame_active || bit_tick) begin
      baud_cnt_reg <= `ASFT_ZERO_BYTE;
    end else if (pre_tick) begin
      baud_cnt_reg <= baud_cnt_reg + `ASFT_CNT_ONE;
    end
  end

  // transmit sequencer

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_state_reg     <= asft_pkg::ASFT_TX_IDLE;
      transmit_shifter <= `ASFT_ZERO_BYTE;
      tx_bit_reg       <= 3'h0;
      tx_stop2_reg     <= 1'b0;
      tx_par_reg       <= 1'b0;
      tx_line_reg      <= 1'b1;
      tx_complete_irq  <= 1'b0;
    end else if (!tx_run) begin
      tx_state_reg    <= asft_pkg::ASFT_TX_IDLE;
      tx_line_reg     <= 1'b1;
      tx_complete_irq <= 1'b0;
    end else begin
      tx_complete_irq <= 1'b0;
      case (tx_state_reg)
        asft_pkg::ASFT_TX_IDLE: begin
          tx_line_reg <= 1'b1;
          if (load_frame) begin
            transmit_shifter <= asft_pkg::asft_order(transmit_buffer, char_length_bit,
                                                     bit_order_bit);
            case (parity_mode)
              asft_pkg::ASFT_PAR_EVEN:
                tx_par_reg <= asft_pkg::asft_ones_odd(transmit_buffer, char_length_bit);
              asft_pkg::ASFT_PAR_ODD:
                tx_par_reg <= !asft_pkg::asft_ones_odd(transmit_buffer, char_length_bit);
              default:
                tx_par_reg <= 1'b0;
            endcase
            tx_bit_reg   <= 3'h0;
            tx_stop2_reg <= stop_length_bit;
            tx_line_reg  <= 1'b0;
            tx_state_reg <= asft_pkg::ASFT_TX_START;
          end
        end
        asft_pkg::ASFT_TX_START: begin
          if (bit_tick) begin
            tx_line_reg  <= transmit_shifter[0];
            tx_state_reg <= asft_pkg::ASFT_TX_DATA;
          end
        end
        asft_pkg::ASFT_TX_DATA: begin
          if (bit_tick) begin
            transmit_shifter <= {1'b0, transmit_shifter[7:1]};
            tx_bit_reg       <= tx_bit_reg + `ASFT_BIT_ONE;
            if (tx_bit_reg == (char_length_bit ? `ASFT_CHAR8_LAST : `ASFT_CHAR7_LAST)) begin
              if (parity_mode == asft_pkg::ASFT_PAR_NONE) begin
                tx_line_reg  <= 1'b1;
                tx_state_reg <= asft_pkg::ASFT_TX_STOP;
              end else begin
                tx_line_reg  <= tx_par_reg;
                tx_state_reg <= asft_pkg::ASFT_TX_PARITY;
              end
            end else begin
              tx_line_reg <= transmit_shifter[1];
            end
          end
        end
        asft_pkg::ASFT_TX_PARITY: begin
          if (bit_tick) begin
            tx_line_reg  <= 1'b1;
            tx_state_reg <= asft_pkg::ASFT_TX_STOP;
          end
        end
        asft_pkg::ASFT_TX_STOP: begin
          if (bit_tick) begin
            if (tx_stop2_reg) begin
              tx_stop2_reg <= 1'b0;
            end else begin
              tx_state_reg    <= asft_pkg::ASFT_TX_IDLE;
              tx_complete_irq <= 1'b1;
            end
          end
        end
        default: tx_state_reg <= asft_pkg::ASFT_TX_IDLE;
      endcase
    end
  end

  // the pin register adds one clock to every edge; inversion covers the whole frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serial_out_pin <= 1'b1;
    end else if (!power_enable_bit) begin
      serial_out_pin <= 1'b1;
    end else begin
      serial_out_pin <= tx_line_reg ^ tx_level_invert_bit;
    end
  end

  // pin ownership; the pair not selected keeps its ordinary function
  assign prim_tx_owned = tx_run && sel_primary;
  assign alt_tx_owned  = tx_run && sel_alternate;
  assign prim_rx_owned = rx_run && sel_primary;
  assign alt_rx_owned  = rx_run && sel_alternate;
  assign prim_tx_pin   = prim_tx_owned ? serial_out_pin : prim_port_out;
  assign alt_tx_pin    = alt_tx_owned ? serial_out_pin : alt_port_out;
  assign rx_line       = prim_rx_owned ? prim_rx_pin :
                         alt_rx_owned  ? alt_rx_pin  : 1'b1;

  asft_rx u_rx (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .clear       (!rx_run),
    .rx_line     (rx_line),
    .pre_tick    (pre_tick),
    .divisor     (baud_divisor_reg),
    .char8       (char_length_bit),
    .parity_mode (parity_mode),
    .lsb_first   (bit_order_bit),
    .done        (rx_done),
    .data        (rx_data),
    .parity_err  (rx_perr),
    .framing_err (rx_ferr)
  );

  // receive buffer is not overwritten while unread data stands in it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_buffer_reg   <= `ASFT_ZERO_BYTE;
      rx_buf_full_reg <= 1'b0;
    end else if (!power_enable_bit) begin
      rx_buffer_reg   <= `ASFT_ZERO_BYTE;
      rx_buf_full_reg <= 1'b0;
    end else if (rx_done) begin
      if (!rx_buf_full_reg || rd_rxbuf) begin
        rx_buffer_reg <= rx_data;
      end
      rx_buf_full_reg <= 1'b1;
    end else if (rd_rxbuf) begin
      rx_buf_full_reg <= 1'b0;
    end
  end

  // sticky error flags; a new error in the clearing read cycle wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_error_status_reg <= `ASFT_ZERO_BYTE;
    end else if (!power_enable_bit) begin
      rx_error_status_reg <= `ASFT_ZERO_BYTE;
    end else if (rx_done) begin
      rx_error_status_reg[`ASFT_ERR_PARITY]  <= rx_perr ||
        (!rd_err && rx_error_status_reg[`ASFT_ERR_PARITY]);
      rx_error_status_reg[`ASFT_ERR_FRAMING] <= rx_ferr ||
        (!rd_err && rx_error_status_reg[`ASFT_ERR_FRAMING]);
      rx_error_status_reg[`ASFT_ERR_OVERRUN] <= (rx_buf_full_reg && !rd_rxbuf) ||
        (!rd_err && rx_error_status_reg[`ASFT_ERR_OVERRUN]);
    end else if (rd_err) begin
      rx_error_status_reg <= `ASFT_ZERO_BYTE;
    end
  end

endmodule
